// file: rtl/nmch_pkg.sv
// Package of constants and types for the network master command handler
`default_nettype none
package nmch_pkg;
   // ==================================================================
   // Command codes
   localparam logic [15:0] NMCH_CMD_OPEN = 16'h0001;
   localparam logic [15:0] NMCH_CMD_OPEN_EX = 16'h0002;
   localparam logic [15:0] NMCH_CMD_IO_START = 16'h1001;
   localparam logic [15:0] NMCH_CMD_IO_STOP = 16'h1002;
   localparam logic [15:0] NMCH_CMD_CYC_STOP = 16'h1003;
   localparam logic [15:0] NMCH_CMD_STAT_RD = 16'h2001;
   localparam logic [15:0] NMCH_CMD_STAT_CLR = 16'h2002;
   // ==================================================================
   // Response codes
   localparam logic [15:0] NMCH_RSP_OK = 16'h0000;
   localparam logic [15:0] NMCH_RSP_HW_BASE = 16'h8100;
   localparam logic [15:0] NMCH_RSP_NOCHG = 16'h8101;
   localparam logic [15:0] NMCH_RSP_HW_MAX = 16'h8109;
   localparam logic [15:0] NMCH_RSP_FMT = 16'hC000;
   localparam logic [15:0] NMCH_RSP_BADCMD = 16'hC0FF;
   // ==================================================================
   // Slave parameter area, word offsets
   localparam logic [15:0] NMCH_OFS_SLV_REQ_MON = 16'h469C;
   localparam logic [15:0] NMCH_OFS_SLV_IO_TMO = 16'h469D;
   localparam logic [15:0] NMCH_SLV_REQ_MON_RST = 16'h0000;
   localparam logic [15:0] NMCH_SLV_IO_TMO_RST = 16'h0000;
   // Defaults and limits, in ms
   localparam logic [15:0] NMCH_REQ_MON_DEF_MS = 16'h07D0; // 2000 ms
   localparam logic [15:0] NMCH_IO_TMO_FAST_MS = 16'h0032; // 50 ms
   localparam logic [15:0] NMCH_IO_TMO_SLOW_MS = 16'h00A3; // 163 ms
   // ==================================================================
   // Extended open argument bits
   localparam int NMCH_FN_STOP_ERR = 0;
   localparam int NMCH_FN_MAN_IO = 1;
   localparam int NMCH_FN_CLR_IN = 2;
   localparam int NMCH_FN_REG_TBL = 8;
   localparam int NMCH_FN_LOGIC = 9;
   localparam int NMCH_FN_NET_PAR = 10;
   localparam int NMCH_FN_SLV_PAR = 11;
   localparam logic [15:0] NMCH_FN_LEGAL = 16'h0F07;
   localparam logic [15:0] NMCH_FMT_BASIC = 16'h0003;
   localparam logic [15:0] NMCH_CLR_LEGAL = 16'h0860;
   localparam logic [15:0] NMCH_RD_LEGAL = 16'h4FFF;
   // Data rate codes
   localparam logic [1:0] NMCH_RATE_93K = 2'h3;
   // Cycles of internal execution for one command
   localparam int NMCH_EXEC_CYC = 2;
   // ==================================================================
   // Handler states
   typedef enum logic [3:0] {
      NMCH_IDLE = 4'b0001,
      NMCH_EXEC = 4'b0010,
      NMCH_WAIT = 4'b0100,
      NMCH_DONE = 4'b1000
   } nmch_state_t;
endpackage : nmch_pkg
`default_nettype wire

// file: rtl/nmch_ctl_if.sv
// Interface carrying decoded command effects between handler modules
`timescale 1ns/1ns
`default_nettype none
interface nmch_ctl_if;
   logic sys_open;
   logic cyc_run;
   logic io_run;
   logic slv_par_en;
   logic [1:0] rate;
   logic [15:0] req_mon_raw;
   logic [15:0] io_tmo_raw;
   logic [15:0] req_mon_eff;
   logic [15:0] io_tmo_eff;
   modport ctl (output sys_open, cyc_run, io_run, slv_par_en, rate,
      req_mon_raw, io_tmo_raw, input req_mon_eff, io_tmo_eff);
   modport par (input sys_open, cyc_run, io_run, slv_par_en, rate,
      req_mon_raw, io_tmo_raw, output req_mon_eff, io_tmo_eff);
endinterface : nmch_ctl_if
`default_nettype wire

// file: rtl/nmch_slv_par.sv
// Effective slave parameter values handed to remote units
`timescale 1ns/1ns
`default_nettype none
module nmch_slv_par
   import nmch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control carrier
   nmch_ctl_if.par ctl
);
   // ==================================================================
   // Range limit for the link rate in use
   logic [15:0] io_max;
   logic [15:0] req_d;
   logic [15:0] io_d;
   logic [15:0] req_q;
   logic [15:0] io_q;
   assign io_max = (ctl.rate == NMCH_RATE_93K) ? NMCH_IO_TMO_SLOW_MS
                                               : NMCH_IO_TMO_FAST_MS;
   // Zero picks the default monitoring time
   always_comb begin
      req_d = (ctl.req_mon_raw == 16'h0000) ? NMCH_REQ_MON_DEF_MS
                                            : ctl.req_mon_raw;
      if (ctl.io_tmo_raw == 16'h0000 || ctl.io_tmo_raw > io_max) begin
         io_d = io_max;
      end else begin
         io_d = ctl.io_tmo_raw;
      end
   end
   // Latched only while the area is enabled, so stale writes stay out
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_q <= NMCH_REQ_MON_DEF_MS;
         io_q <= NMCH_IO_TMO_FAST_MS;
      end else if (ctl.slv_par_en) begin
         req_q <= req_d;
         io_q <= io_d;
      end
   end
   assign ctl.req_mon_eff = req_q;
   assign ctl.io_tmo_eff = io_q;
endmodule : nmch_slv_par
`default_nettype wire

// file: rtl/nmch_cmd.sv
// Top: command interpreter of the network master board
// ==================================================================
`timescale 1ns/1ns
`default_nettype none
module nmch_cmd
   import nmch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Command mailbox from host
   input wire logic cmd_valid_i,
   input wire logic [15:0] cmd_code_i,
   input wire logic [15:0] cmd_arg_i,
   output logic cmd_busy_o,
   output logic rsp_valid_o,
   output logic [15:0] rsp_code_o,
   // Shared-memory slave parameter words
   input wire logic par_we_i,
   input wire logic [15:0] par_addr_i,
   input wire logic [15:0] par_wdata_i,
   output logic [15:0] par_rdata_o,
   // Setting area checks from the board
   input wire logic [15:0] area_fmt_err_i,
   input wire logic [1:0] rate_i,
   input wire logic [3:0] hw_fault_i,
   // Network control outputs
   output logic cyc_run_o,
   output logic io_run_o,
   output logic [15:0] fn_en_o,
   output logic stat_copy_o,
   output logic stat_clr_o,
   output logic [15:0] stat_sel_o,
   // Values passed to remote units
   output logic [15:0] req_mon_ms_o,
   output logic [15:0] io_tmo_ms_o,
   output logic [17:0] io_tmo_remote_ms_o
);
   // ==================================================================
   // Declarations
   nmch_ctl_if ctl ();
   nmch_state_t state_q;
   logic [15:0] code_q;
   logic [15:0] arg_q;
   logic [15:0] rsp_q;
   logic rsp_valid_q;
   logic [1:0] exec_cnt_q;
   logic sys_open_q;
   logic cyc_run_q;
   logic cyc_dead_q;
   logic io_run_q;
   logic [15:0] fn_q;
   logic [15:0] req_raw_q;
   logic [15:0] io_raw_q;
   logic slv_apply_q;
   logic stat_copy_q;
   logic stat_clr_q;
   logic [15:0] stat_sel_q;
   logic [15:0] rsp_d;
   logic apply;

   // Lowest set error bit among the areas the command checks
   function automatic logic [15:0] fmt_code(input logic [15:0] err);
      logic [15:0] r;
      r = NMCH_RSP_OK;
      for (int i = 15; i >= 0; i--) begin
         if (err[i]) begin
            r = NMCH_RSP_FMT + 16'(i);
         end
      end
      return r;
   endfunction : fmt_code

   // Hardware fault index maps into 0x8101..0x8109
   function automatic logic [15:0] hw_code(input logic [3:0] f);
      logic [3:0] c;
      c = (f > 4'h9) ? 4'h9 : f;
      return NMCH_RSP_HW_BASE + {12'h000, c};
   endfunction : hw_code

   // ==================================================================
   // Response decision, evaluated once the command is latched
   always_comb begin
      logic [15:0] chk;
      chk = 16'h0000;
      rsp_d = NMCH_RSP_OK;
      unique case (code_q)
         NMCH_CMD_OPEN: begin
            // Basic open checks table and rate only
            chk = area_fmt_err_i & NMCH_FMT_BASIC;
            if (hw_fault_i != 4'h0) begin
               rsp_d = hw_code(hw_fault_i);
            end else if (chk != 16'h0000) begin
               rsp_d = fmt_code(chk);
            end else if (arg_q != 16'h0000) begin
               rsp_d = NMCH_RSP_FMT;
            end
         end
         NMCH_CMD_OPEN_EX: begin
            // Optional areas checked only when enabled
            chk = area_fmt_err_i & (NMCH_FMT_BASIC | (arg_q & 16'h0F00));
            if (hw_fault_i != 4'h0) begin
               rsp_d = hw_code(hw_fault_i);
            end else if (chk != 16'h0000) begin
               rsp_d = fmt_code(chk);
            end else if ((arg_q & ~NMCH_FN_LEGAL) != 16'h0000) begin
               rsp_d = fmt_code(arg_q & ~NMCH_FN_LEGAL);
            end
         end
         NMCH_CMD_IO_START: begin
            if (!cyc_run_q || io_run_q) begin
               rsp_d = NMCH_RSP_NOCHG;
            end
         end
         NMCH_CMD_IO_STOP: begin
            if (!cyc_run_q || !io_run_q) begin
               rsp_d = NMCH_RSP_NOCHG;
            end
         end
         NMCH_CMD_CYC_STOP: begin
            if (!cyc_run_q) begin
               rsp_d = NMCH_RSP_NOCHG;
            end
         end
         NMCH_CMD_STAT_RD: begin
            if ((arg_q & ~NMCH_RD_LEGAL) != 16'h0000) begin
               rsp_d = fmt_code(arg_q & ~NMCH_RD_LEGAL);
            end
         end
         NMCH_CMD_STAT_CLR: begin
            if ((arg_q & ~NMCH_CLR_LEGAL) != 16'h0000) begin
               rsp_d = fmt_code(arg_q & ~NMCH_CLR_LEGAL);
            end
         end
         default: rsp_d = NMCH_RSP_BADCMD;
      endcase
   end

   // Effects take place in the cycle the state leaves EXEC
   assign apply = (state_q == NMCH_EXEC) && (rsp_d == NMCH_RSP_OK);

   // ==================================================================
   // Sequencer: one command at a time, answer after effects
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= NMCH_IDLE;
         code_q <= 16'h0000;
         arg_q <= 16'h0000;
         exec_cnt_q <= 2'h0;
      end else begin
         unique case (state_q)
            NMCH_IDLE: begin
               if (cmd_valid_i) begin
                  code_q <= cmd_code_i;
                  arg_q <= cmd_arg_i;
                  state_q <= NMCH_EXEC;
               end
            end
            NMCH_EXEC: begin
               exec_cnt_q <= 2'(NMCH_EXEC_CYC);
               state_q <= NMCH_WAIT;
            end
            NMCH_WAIT: begin
               // Lets the effects settle before the host sees an answer
               if (exec_cnt_q == 2'h1) begin
                  state_q <= NMCH_DONE;
               end
               exec_cnt_q <= exec_cnt_q - 2'h1;
            end
            NMCH_DONE: state_q <= NMCH_IDLE;
         endcase
      end
   end

   // Response register, captured in EXEC and published in DONE
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rsp_q <= NMCH_RSP_OK;
         rsp_valid_q <= 1'b0;
      end else begin
         if (state_q == NMCH_EXEC) begin
            rsp_q <= rsp_d;
         end
         rsp_valid_q <= (state_q == NMCH_WAIT) && (exec_cnt_q == 2'h1);
      end
   end

   // ==================================================================
   // System and communications state
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sys_open_q <= 1'b0;
         cyc_run_q <= 1'b0;
         cyc_dead_q <= 1'b0;
         io_run_q <= 1'b0;
         fn_q <= 16'h0000;
      end else if (apply) begin
         unique case (code_q)
            NMCH_CMD_OPEN: begin
               if (!cyc_dead_q) begin
                  sys_open_q <= 1'b1;
                  cyc_run_q <= 1'b1;
                  io_run_q <= 1'b1;
                  fn_q <= 16'h0000;
               end
            end
            NMCH_CMD_OPEN_EX: begin
               if (!cyc_dead_q) begin
                  sys_open_q <= 1'b1;
                  cyc_run_q <= 1'b1;
                  fn_q <= arg_q;
                  // Manual startup holds I/O until a start command
                  io_run_q <= ~arg_q[NMCH_FN_MAN_IO];
               end
            end
            NMCH_CMD_IO_START: io_run_q <= 1'b1;
            NMCH_CMD_IO_STOP: io_run_q <= 1'b0;
            NMCH_CMD_CYC_STOP: begin
               // Only reset brings the cycles back
               cyc_run_q <= 1'b0;
               io_run_q <= 1'b0;
               cyc_dead_q <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ==================================================================
   // Status copy and clear strobes
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stat_copy_q <= 1'b0;
         stat_clr_q <= 1'b0;
         stat_sel_q <= 16'h0000;
      end else begin
         stat_copy_q <= apply && (code_q == NMCH_CMD_STAT_RD);
         stat_clr_q <= apply && (code_q == NMCH_CMD_STAT_CLR);
         if (apply) begin
            stat_sel_q <= arg_q;
         end
      end
   end

   // ==================================================================
   // Slave parameter words in shared memory
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_raw_q <= NMCH_SLV_REQ_MON_RST;
         io_raw_q <= NMCH_SLV_IO_TMO_RST;
         slv_apply_q <= 1'b0;
      end else begin
         if (par_we_i && par_addr_i == NMCH_OFS_SLV_REQ_MON) begin
            req_raw_q <= par_wdata_i;
         end
         if (par_we_i && par_addr_i == NMCH_OFS_SLV_IO_TMO) begin
            io_raw_q <= par_wdata_i;
         end
         // One-cycle apply on a successful extended open with bit 11
         slv_apply_q <= apply && (code_q == NMCH_CMD_OPEN_EX)
                        && arg_q[NMCH_FN_SLV_PAR];
      end
   end

   // Readback of the parameter words, zero elsewhere
   always_comb begin
      par_rdata_o = 16'h0000;
      if (par_addr_i == NMCH_OFS_SLV_REQ_MON) begin
         par_rdata_o = req_raw_q;
      end else if (par_addr_i == NMCH_OFS_SLV_IO_TMO) begin
         par_rdata_o = io_raw_q;
      end
   end

   // ==================================================================
   // Carrier to the parameter limiter
   assign ctl.sys_open = sys_open_q;
   assign ctl.cyc_run = cyc_run_q;
   assign ctl.io_run = io_run_q;
   assign ctl.slv_par_en = slv_apply_q;
   assign ctl.rate = rate_i;
   assign ctl.req_mon_raw = req_raw_q;
   assign ctl.io_tmo_raw = io_raw_q;

   nmch_slv_par u_slv_par (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .ctl(ctl)
   );

   // ==================================================================
   // Outputs
   assign cmd_busy_o = (state_q != NMCH_IDLE);
   assign rsp_valid_o = rsp_valid_q;
   assign rsp_code_o = rsp_q;
   assign cyc_run_o = cyc_run_q;
   assign io_run_o = io_run_q;
   assign fn_en_o = fn_q;
   assign stat_copy_o = stat_copy_q;
   assign stat_clr_o = stat_clr_q;
   assign stat_sel_o = stat_sel_q;
   assign req_mon_ms_o = ctl.req_mon_eff;
   assign io_tmo_ms_o = ctl.io_tmo_eff;
   // Remote units time out at four times the set value
   assign io_tmo_remote_ms_o = {ctl.io_tmo_eff, 2'b00};
endmodule : nmch_cmd
`default_nettype wire

// file: sim/nmch_cmd_chk.sv
// Assertion checker watching the command handler top-level ports
`timescale 1ns/1ns
`default_nettype none
module nmch_cmd_chk
   import nmch_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Mailbox
   input wire logic cmd_valid_i,
   input wire logic cmd_busy_o,
   input wire logic rsp_valid_o,
   input wire logic [15:0] rsp_code_o,
   // Network effects
   input wire logic cyc_run_o,
   input wire logic io_run_o,
   input wire logic stat_copy_o,
   input wire logic stat_clr_o,
   input wire logic [15:0] req_mon_ms_o,
   input wire logic [15:0] io_tmo_ms_o,
   input wire logic [17:0] io_tmo_remote_ms_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // ==================================================================
   // Mailbox timing: busy for the whole walk, answer on the fourth edge
   property p_answer;
      cmd_valid_i && !cmd_busy_o |=> cmd_busy_o [*3] ##1 rsp_valid_o;
   endproperty
   a_answer: assert property (p_answer)
      else $error("answer not on fourth cycle");
   property p_pulse; rsp_valid_o |=> !rsp_valid_o && !cmd_busy_o; endproperty
   a_pulse: assert property (p_pulse)
      else $error("answer pulse too long");
   // Idle handler must not touch the answer or the run state
   property p_hold; !cmd_busy_o |=> $stable(rsp_code_o); endproperty
   a_hold: assert property (p_hold)
      else $error("response code moved while idle");
   property p_quiet;
      !cmd_busy_o |=> $stable(cyc_run_o) && $stable(io_run_o);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("run state moved while idle");
   property p_io_cyc; io_run_o |-> cyc_run_o; endproperty
   a_io_cyc: assert property (p_io_cyc)
      else $error("exchange running without cycles");
   // ==================================================================
   // Status strobes: single pulse, only inside a command
   property p_copy; stat_copy_o |-> cmd_busy_o ##1 !stat_copy_o; endproperty
   a_copy: assert property (p_copy)
      else $error("bad copy strobe");
   property p_clr; stat_clr_o |-> cmd_busy_o ##1 !stat_clr_o; endproperty
   a_clr: assert property (p_clr)
      else $error("bad clear strobe");
   // ==================================================================
   // Values handed to remote units
   property p_rem; io_tmo_remote_ms_o == {io_tmo_ms_o, 2'b00}; endproperty
   a_rem: assert property (p_rem)
      else $error("remote timeout not four times");
   property p_rng;
      io_tmo_ms_o != 16'h0000 && io_tmo_ms_o <= NMCH_IO_TMO_SLOW_MS;
   endproperty
   a_rng: assert property (p_rng)
      else $error("timeout outside range");
   property p_mon; req_mon_ms_o != 16'h0000; endproperty
   a_mon: assert property (p_mon)
      else $error("request monitor zero");
   c_ok: cover property (rsp_valid_o && rsp_code_o == NMCH_RSP_OK);
   c_clr: cover property (stat_clr_o);
   c_stop: cover property ($fell(cyc_run_o));
endmodule : nmch_cmd_chk
`default_nettype wire

// file: sim/nmch_host_mdl.sv
// Host software model: mailbox commands and shared-memory writes
`timescale 1ns/1ns
`default_nettype none
module nmch_host_mdl (
   // Clock
   input wire logic clk_i,
   // Mailbox
   output logic cmd_valid_o,
   output logic [15:0] cmd_code_o,
   output logic [15:0] cmd_arg_o,
   input wire logic rsp_valid_i,
   input wire logic [15:0] rsp_code_i,
   // Slave parameter words
   output logic par_we_o,
   output logic [15:0] par_addr_o,
   output logic [15:0] par_wdata_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 16'h0000;
      cmd_arg_o = 16'h0000;
      par_we_o = 1'b0;
      par_addr_o = 16'h469C;
      par_wdata_o = 16'h0000;
   end
   // One command at a time; waits for the answer, bounded
   task automatic send(input logic [15:0] code, input logic [15:0] arg,
      output logic [15:0] rsp, output int lat);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= code;
      cmd_arg_o <= arg;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o <= ~code; // Stale mailbox shows junk, not the old code
      cmd_arg_o <= ~arg;
      lat = 0;
      while (lat < 12 && rsp_valid_i !== 1'b1) begin
         @(posedge clk_i);
         lat++;
      end
      rsp = rsp_code_i;
   endtask : send
   // Slave area is filled before the extended open applies it
   task automatic put(input logic [15:0] addr, input logic [15:0] data);
      @(posedge clk_i);
      par_we_o <= 1'b1;
      par_addr_o <= addr;
      par_wdata_o <= data;
      @(posedge clk_i);
      par_we_o <= 1'b0;
      par_wdata_o <= ~data;
      // Readback only settles after the write edge has been taken
      @(posedge clk_i);
   endtask : put
endmodule : nmch_host_mdl
`default_nettype wire

// file: sim/tb.sv
// Self-checking testbench of the command handler
`timescale 1ns/1ns
`default_nettype none
module tb;
   import nmch_pkg::*;
   logic clk = 1'b0, nrst, cv, we, busy, rv, cyc, io, cp, cl;
   logic [15:0] cc, ca, pa, pw, rd, fmt, fn, sel, rm, tmo, rc, rsp, tr, rr;
   logic [1:0] rate;
   logic [3:0] hw;
   logic [17:0] rem;
   logic [31:0] rng = 32'd2904;
   int fails = 0, samples_checked = 0, ticks = 0, lat, n_cp = 0, n_cl = 0;
   // ==================================================================
   // Clock, strobe counters and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      n_cp += int'(cp === 1'b1);
      n_cl += int'(cl === 1'b1);
      ticks++;
      if (ticks > 5000) begin
         fails++;
         wrap_up();
      end
   end
   nmch_cmd nmch_cmd_i (.clk_i(clk), .nrst_i(nrst), .cmd_valid_i(cv),
      .cmd_code_i(cc), .cmd_arg_i(ca), .cmd_busy_o(busy), .rsp_valid_o(rv),
      .rsp_code_o(rc), .par_we_i(we), .par_addr_i(pa), .par_wdata_i(pw),
      .par_rdata_o(rd), .area_fmt_err_i(fmt), .rate_i(rate),
      .hw_fault_i(hw), .cyc_run_o(cyc), .io_run_o(io), .fn_en_o(fn),
      .stat_copy_o(cp), .stat_clr_o(cl), .stat_sel_o(sel),
      .req_mon_ms_o(rm), .io_tmo_ms_o(tmo), .io_tmo_remote_ms_o(rem));
   nmch_host_mdl host_i (.clk_i(clk), .cmd_valid_o(cv), .cmd_code_o(cc),
      .cmd_arg_o(ca), .rsp_valid_i(rv), .rsp_code_i(rc), .par_we_o(we),
      .par_addr_o(pa), .par_wdata_o(pw));
   // ==================================================================
   // Helpers
   function automatic logic [15:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[15:0];
   endfunction : xs
   function automatic logic [15:0] lim(input logic [1:0] r);
      return (r == NMCH_RATE_93K) ? 16'h00A3 : 16'h0032;
   endfunction : lim
   function automatic logic [15:0] exp_io(input logic [15:0] v);
      return (v == 16'h0000 || v > lim(rate)) ? lim(rate) : v;
   endfunction : exp_io
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cmd(input logic [15:0] c, input logic [15:0] a,
      input logic [15:0] e);
      host_i.send(c, a, rsp, lat);
      check(rsp, e);
      check(32'(lat), 32'h0000_0004);
   endtask : cmd
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
   endtask : do_reset
   task automatic wrap_up();
      $display("checks=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   // ==================================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      fmt = 16'h0000; // Host filled table and rate
      rate = 2'h0;
      hw = 4'h0;
      do_reset();
      @(posedge clk);
      check(rm, 16'd2000);
      check(rem, 18'd200);
      check(rd, 16'h0000);
      host_i.put(16'h469E, 16'h1234);
      check(rd, 16'h0000);
      host_i.put(NMCH_OFS_SLV_REQ_MON, 16'h0007);
      check(rd, 16'h0007);
      // Refused opens leave everything stopped
      hw <= 4'h3;
      cmd(NMCH_CMD_OPEN, 16'h0000, 16'h8103);
      hw <= 4'h0;
      fmt <= 16'h0002;
      cmd(NMCH_CMD_OPEN, 16'h0000, 16'hC001);
      fmt <= 16'h0000;
      cmd(NMCH_CMD_OPEN, 16'h0001, 16'hC000);
      cmd(16'h5555, 16'h0000, NMCH_RSP_BADCMD);
      check(cyc, 1'b0);
      cmd(NMCH_CMD_OPEN, 16'h0000, 16'h0000);
      check({cyc, io, fn}, 18'h3_0000);
      check(rm, 16'd2000);
      // I/O exchange stop and restart, with redundant requests
      cmd(NMCH_CMD_IO_START, 16'h0000, 16'h8101);
      cmd(NMCH_CMD_IO_STOP, 16'h0000, 16'h0000);
      check({cyc, io}, 2'b10);
      cmd(NMCH_CMD_IO_STOP, 16'h0000, 16'h8101);
      cmd(NMCH_CMD_IO_START, 16'h0000, 16'h0000);
      check(io, 1'b1);
      // Status copy and clear with random item selections
      for (int i = 0; i < 6; i++) begin
         tr = xs() & NMCH_RD_LEGAL;
         cmd(NMCH_CMD_STAT_RD, tr, 16'h0000);
         check(sel, tr);
         tr = xs() & NMCH_CLR_LEGAL;
         cmd(NMCH_CMD_STAT_CLR, tr, 16'h0000);
      end
      cmd(NMCH_CMD_STAT_RD, 16'h1000, 16'hC00C);
      cmd(NMCH_CMD_STAT_CLR, 16'h0001, 16'hC000);
      check(n_cp, 6);
      check(n_cl, 6);
      // Cycle stop holds until reset
      cmd(NMCH_CMD_CYC_STOP, 16'h0000, 16'h0000);
      check({cyc, io}, 2'b00);
      cmd(NMCH_CMD_CYC_STOP, 16'h0000, 16'h8101);
      cmd(NMCH_CMD_IO_START, 16'h0000, 16'h8101);
      cmd(NMCH_CMD_OPEN, 16'h0000, 16'h0000);
      check(cyc, 1'b0);
      // Extended open applies slave words per rate, boundary cases first
      for (int i = 0; i < 8; i++) begin
         do_reset();
         check(cyc, 1'b0);
         rate <= 2'(i + 1);
         @(posedge clk);
         rr = (i == 0) ? 16'h0000 : xs();
         tr = (i == 0) ? 16'h0000 : (i == 1) ? lim(rate) :
            (i == 2) ? lim(rate) + 16'h0001 : (xs() & 16'h00FF);
         host_i.put(NMCH_OFS_SLV_REQ_MON, rr);
         host_i.put(NMCH_OFS_SLV_IO_TMO, tr);
         check(rd, tr);
         cmd(NMCH_CMD_OPEN_EX, 16'h0802, 16'h0000);
         check({cyc, io, fn}, 18'h2_0802);
         check(rm, (rr == 16'h0000) ? 16'd2000 : rr);
         check(tmo, exp_io(tr));
         check(rem, {exp_io(tr), 2'b00});
         cmd(NMCH_CMD_IO_START, 16'h0000, 16'h0000);
      end
      // Extended open refusals and unselected areas
      do_reset();
      host_i.put(NMCH_OFS_SLV_REQ_MON, 16'h0064);
      cmd(NMCH_CMD_OPEN_EX, 16'h0808, 16'hC003);
      fmt <= 16'h0100;
      cmd(NMCH_CMD_OPEN_EX, 16'h0100, 16'hC008);
      fmt <= 16'h0800;
      cmd(NMCH_CMD_OPEN_EX, 16'h0800, 16'hC00B);
      cmd(NMCH_CMD_OPEN_EX, 16'h0001, 16'h0000);
      check({cyc, io, fn}, 18'h3_0001);
      check(rm, 16'd2000);
      wrap_up();
   end
endmodule : tb
bind nmch_cmd nmch_cmd_chk nmch_cmd_chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
   .cmd_valid_i(cmd_valid_i), .cmd_busy_o(cmd_busy_o),
   .rsp_valid_o(rsp_valid_o), .rsp_code_o(rsp_code_o),
   .cyc_run_o(cyc_run_o), .io_run_o(io_run_o), .stat_copy_o(stat_copy_o),
   .stat_clr_o(stat_clr_o), .req_mon_ms_o(req_mon_ms_o),
   .io_tmo_ms_o(io_tmo_ms_o), .io_tmo_remote_ms_o(io_tmo_remote_ms_o));
`default_nettype wire
